// *** hw/drive_cmd_regs.svh ***
// Constants for the serial command and drive condition word logic.
// Assumes inclusion by bare name from the design file.
`ifndef DRIVE_CMD_REGS_SVH
`define DRIVE_CMD_REGS_SVH
// ==================================================================
// Command word bit positions
`define CW_PRESET_LSB 0
`define CW_PRESET_MSB 1
`define CW_DC_BRAKE_N 2
`define CW_COAST_N 3
`define CW_QUICK_STOP_N 4
`define CW_FREEZE_N 5
`define CW_START 6
`define CW_TRIP_RESET 7
`define CW_JOG 8
`define CW_DATA_VALID 10
`define CW_RELAY1 11
`define CW_RELAY2 12
`define CW_SETUP_LSB 13
`define CW_SETUP_MSB 14
`define CW_REVERSE 15
// ==================================================================
// Status word bit positions
`define SW_CONTROL_READY 0
`define SW_DRIVE_READY 1
`define SW_STANDBY 2
`define SW_TRIP 3
`define SW_WARNING 7
`define SW_AT_REF 8
`define SW_SERIAL_CTRL 9
`define SW_IN_RANGE 10
`define SW_RUNNING 11
`define SW_VOLT_WARN 13
`define SW_CURR_LIMIT 14
`define SW_THERMAL 15
// ==================================================================
// Reset values
`define CMD_RESET 16'h0000
`define WORD_RESET 16'h0000
// Bus time-out default, in milliseconds
`define BUS_TIMEOUT_MS 1000
`define CLK_KHZ 25000
`endif

// *** hw/drive_cmd_pkg.sv ***
// Types for the serial command and drive condition word logic.
// Assumes the constants header sits beside it.
`default_nettype none
package drive_cmd_pkg;
  // ================================================================
  // Gating choice between serial bit and digital input
  typedef enum logic [1:0] {
    gate_digital = 2'h0,
    gate_serial = 2'h1,
    gate_and = 2'h2,
    gate_or = 2'h3
  } gate_sel_t;

  // ================================================================
  // Digital inputs, active high requests
  typedef struct packed {
    logic coast;
    logic dc_brake;
    logic start;
    logic reverse;
    logic [1:0] setup;
    logic [1:0] preset;
    logic speed_up;
    logic speed_down;
  } dig_in_t;

  // ================================================================
  // Per-function gating selections
  typedef struct packed {
    gate_sel_t coast;
    gate_sel_t dc_brake;
    gate_sel_t start;
    gate_sel_t reverse;
    gate_sel_t setup;
    gate_sel_t preset;
  } gate_cfg_t;

  // ================================================================
  // Decoded drive commands
  typedef struct packed {
    logic [1:0] preset_sel;
    logic dc_brake;
    logic coast;
    logic quick_stop;
    logic freeze;
    logic ramp_stop;
    logic run;
    logic trip_reset;
    logic jog;
    logic relay1;
    logic relay2;
    logic [1:0] setup_sel;
    logic reverse;
  } drive_cmd_t;

  // ================================================================
  // Condition flags from the drive core
  typedef struct packed {
    logic tripped;
    logic warning;
    logic at_ref;
    logic serial_ctrl;
    logic in_range;
    logic running;
    logic volt_warn;
    logic curr_limit;
    logic thermal;
  } drive_flags_t;

  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_got_first = 3'h2,
    st_apply = 3'h4
  } rx_state_t;

  typedef struct packed {
    rx_state_t rx_state;
    logic [15:0] cmd_word;
    logic [15:0] ref_word;
    logic [15:0] first_word;
    logic prev_reset_bit;
    drive_cmd_t cmd;
    logic [15:0] status_word;
    logic [15:0] freq_word;
    logic reply_valid;
    logic timed_out;
    logic [31:0] idle_count;
  } state_t;
endpackage
`default_nettype wire

// *** hw/drive_cmd_logic.sv ***
// Command word decoder and condition word builder for a motor drive.
// Assumes a link layer delivering process words one at a time in order,
// and a drive core providing its condition flags and output frequency.
//
// Summary of operation
// - Parameter values are integers times conversion factor
// - Process block: command/reference in, status/frequency out
// - Command bits 01:00 pick preset reference
// - Bit 02 low applies DC braking
// - Bit 03 low coasts; high permits start
// - Bit 04 low does quick ramp stop
// - Bit 05 low freezes output frequency
// - Frozen drive stops only by coast or brake
// - Bit 07 resets trip on rising edge only
// - Bit 08 high selects jog frequency
// - Bit 10 low ignores whole command word
// - Bits 11/12 drive relays when configured
// - Bus time-out drops serially set relays
// - Bits 14:13 pick setup under multi-setup
// - Bit 15 reverses unless source is digital
// - Command bit 09, status 04-06,12 unused
// - Status bit 00 ready, zero when tripped
// - Status bit 01 ready but coast held
// - Functions gated with digital inputs per selection
// - And-gating needs both; serial-only uses bit
// - Status bit 03 set while tripped
`include "drive_cmd_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module drive_cmd_logic #(
  parameter int unsigned TIMEOUT_CYCLES = `BUS_TIMEOUT_MS * `CLK_KHZ
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [15:0] rx_word,
  input wire logic rx_word_valid,
  input wire logic rx_frame_end,
  input wire logic reply_req,
  input wire logic [15:0] out_freq,
  input wire drive_cmd_pkg::dig_in_t dig_in,
  input wire drive_cmd_pkg::gate_cfg_t gate_cfg,
  input wire drive_cmd_pkg::drive_flags_t flags,
  input wire logic relay1_follows_bus,
  input wire logic relay2_follows_bus,
  input wire logic multi_setup_en,
  output logic [15:0] process_word_first,
  output logic [15:0] process_word_second,
  output logic reply_valid,
  output logic [15:0] ref_word,
  output drive_cmd_pkg::drive_cmd_t cmd
);

  // ================================================================
  // Gating functions
  function automatic logic gate_bit(input drive_cmd_pkg::gate_sel_t sel,
                                    input logic bus_req, input logic dig_req);
    case (sel)
      drive_cmd_pkg::gate_serial: gate_bit = bus_req;
      drive_cmd_pkg::gate_and: gate_bit = bus_req & dig_req;
      drive_cmd_pkg::gate_or: gate_bit = bus_req | dig_req;
      default: gate_bit = dig_req;
    endcase
  endfunction

  function automatic logic [1:0] gate_pair(input drive_cmd_pkg::gate_sel_t sel,
                                           input logic [1:0] bus_v,
                                           input logic [1:0] dig_v);
    case (sel)
      drive_cmd_pkg::gate_serial: gate_pair = bus_v;
      drive_cmd_pkg::gate_and: gate_pair = bus_v & dig_v;
      drive_cmd_pkg::gate_or: gate_pair = bus_v | dig_v;
      default: gate_pair = dig_v;
    endcase
  endfunction

  drive_cmd_pkg::state_t state_reg;
  drive_cmd_pkg::state_t state_next;
  logic [15:0] cw;
  logic coast_req;
  logic brake_req;
  logic start_req;

  // ================================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    cw = state_reg.cmd_word;
    // Requests, active high; bus bits for stop functions are active low
    coast_req = gate_bit(gate_cfg.coast, ~cw[`CW_COAST_N], dig_in.coast);
    brake_req = gate_bit(gate_cfg.dc_brake, ~cw[`CW_DC_BRAKE_N], dig_in.dc_brake);
    start_req = gate_bit(gate_cfg.start, cw[`CW_START], dig_in.start);

    // Words arrive first then second; a frame end without both is dropped
    case (state_reg.rx_state)
      drive_cmd_pkg::st_idle: begin
        if (rx_word_valid) begin
          state_next.first_word = rx_word;
          state_next.rx_state = drive_cmd_pkg::st_got_first;
        end
      end
      drive_cmd_pkg::st_got_first: begin
        if (rx_word_valid) begin
          // Bit 10 low: parameter-only telegram leaves command word alone but restarts the watchdog
          if (state_reg.first_word[`CW_DATA_VALID]) begin
            state_next.cmd_word = state_reg.first_word;
            state_next.ref_word = rx_word;
            state_next.rx_state = drive_cmd_pkg::st_apply;
          end else begin
            state_next.rx_state = drive_cmd_pkg::st_idle;
          end
          state_next.idle_count = 32'h0000_0000;
          state_next.timed_out = 1'b0;
        end else if (rx_frame_end) begin
          state_next.rx_state = drive_cmd_pkg::st_idle;
        end
      end
      drive_cmd_pkg::st_apply: begin
        state_next.rx_state = drive_cmd_pkg::st_idle;
      end
      default: state_next.rx_state = drive_cmd_pkg::st_idle;
    endcase

    // Bus time-out watchdog
    if (!rx_word_valid && !state_reg.timed_out) begin
      if (state_reg.idle_count >= TIMEOUT_CYCLES - 1) begin
        state_next.timed_out = 1'b1;
      end else begin
        state_next.idle_count = state_reg.idle_count + 32'h0000_0001;
      end
    end

    // Decode applied command word; held until the next valid one
    state_next.cmd.preset_sel = gate_pair(gate_cfg.preset,
      {cw[`CW_PRESET_MSB], cw[`CW_PRESET_LSB]}, dig_in.preset);
    state_next.cmd.dc_brake = brake_req;
    state_next.cmd.coast = coast_req;
    state_next.cmd.quick_stop = ~cw[`CW_QUICK_STOP_N];
    state_next.cmd.freeze = ~cw[`CW_FREEZE_N];
    // Freeze masks start/ramp stop; only coast or brake end it
    state_next.cmd.run = state_reg.cmd.freeze ? (state_reg.cmd.run & ~coast_req & ~brake_req)
                         : (start_req & ~coast_req & ~brake_req);
    state_next.cmd.ramp_stop = ~state_reg.cmd.freeze & ~start_req;
    state_next.cmd.trip_reset = 1'b0;
    if (state_reg.rx_state == drive_cmd_pkg::st_apply) begin
      state_next.prev_reset_bit = cw[`CW_TRIP_RESET];
      state_next.cmd.trip_reset = cw[`CW_TRIP_RESET] & ~state_reg.prev_reset_bit;
    end
    state_next.cmd.jog = cw[`CW_JOG];
    // Bit 09 ignored entirely
    state_next.cmd.relay1 = relay1_follows_bus & cw[`CW_RELAY1] & ~state_next.timed_out;
    state_next.cmd.relay2 = relay2_follows_bus & cw[`CW_RELAY2] & ~state_next.timed_out;
    if (multi_setup_en) begin
      state_next.cmd.setup_sel = gate_pair(gate_cfg.setup,
        {cw[`CW_SETUP_MSB], cw[`CW_SETUP_LSB]}, dig_in.setup);
    end else begin
      state_next.cmd.setup_sel = 2'h0;
    end
    state_next.cmd.reverse = gate_bit(gate_cfg.reverse, cw[`CW_REVERSE], dig_in.reverse);

    // Reply words sampled only on request
    state_next.reply_valid = 1'b0;
    if (reply_req) begin
      state_next.status_word = `WORD_RESET;
      state_next.status_word[`SW_CONTROL_READY] = ~flags.tripped;
      state_next.status_word[`SW_DRIVE_READY] = ~flags.tripped & coast_req;
      state_next.status_word[`SW_STANDBY] = ~flags.tripped & ~coast_req & ~brake_req;
      state_next.status_word[`SW_TRIP] = flags.tripped;
      state_next.status_word[`SW_WARNING] = flags.warning;
      state_next.status_word[`SW_AT_REF] = flags.at_ref;
      state_next.status_word[`SW_SERIAL_CTRL] = flags.serial_ctrl;
      state_next.status_word[`SW_IN_RANGE] = flags.in_range;
      state_next.status_word[`SW_RUNNING] = flags.running;
      state_next.status_word[`SW_VOLT_WARN] = flags.volt_warn;
      state_next.status_word[`SW_CURR_LIMIT] = flags.curr_limit;
      state_next.status_word[`SW_THERMAL] = flags.thermal;
      state_next.freq_word = out_freq;
      state_next.reply_valid = 1'b1;
    end
  end

  // ================================================================
  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.rx_state <= drive_cmd_pkg::st_idle;
      state_reg.cmd_word <= `CMD_RESET;
      state_reg.prev_reset_bit <= 1'b1;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // ================================================================
  // Outputs; parameter values stay integer, scaling is downstream
  assign process_word_first = state_reg.status_word;
  assign process_word_second = state_reg.freq_word;
  assign reply_valid = state_reg.reply_valid;
  assign ref_word = state_reg.ref_word;
  assign cmd = state_reg.cmd;

endmodule

`default_nettype wire

// *** test/drive_cmd_checker.sv ***
// Port assertions for the command and condition word logic.
// Assumes binding onto drive_cmd_logic; one clock, synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module drive_cmd_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [15:0] rx_word,
  input wire logic reply_req,
  input wire logic [15:0] out_freq,
  input wire drive_cmd_pkg::drive_flags_t flags,
  input wire logic [15:0] process_word_first,
  input wire logic [15:0] process_word_second,
  input wire logic reply_valid,
  input wire logic [15:0] ref_word,
  input wire drive_cmd_pkg::drive_cmd_t cmd
);
  logic take;
  assign take = reply_req & clk_en;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==================================================================
  // Reply words, sampled at the request edge
  a_reply_pulse: assert property (take |=> reply_valid)
    else $error("no reply after request");
  a_freq_word: assert property (take |=> process_word_second == $past(out_freq))
    else $error("frequency word not sampled");
  a_ready_bit: assert property (take |=> process_word_first[0] != $past(flags.tripped))
    else $error("ready bit wrong");
  a_trip_bit: assert property (take |=> process_word_first[3] == $past(flags.tripped))
    else $error("trip bit wrong");
  a_flag_bits: assert property (take |=>
    process_word_first[11:7] == $past({flags.running, flags.in_range,
    flags.serial_ctrl, flags.at_ref, flags.warning}))
    else $error("flag bits wrong");
  a_unused_bits: assert property (
    process_word_first[6:4] == 3'h0 && !process_word_first[12])
    else $error("unused status bits set");
  // ==================================================================
  // Command side
  a_ref_source: assert property ($changed(ref_word) |-> ref_word == $past(rx_word))
    else $error("reference not from second word");
  a_trip_once: assert property (cmd.trip_reset |=> !cmd.trip_reset)
    else $error("trip reset longer than one cycle");
endmodule
bind drive_cmd_logic drive_cmd_checker u_drive_cmd_checker (
  .clk, .rst_n, .clk_en, .rx_word, .reply_req, .out_freq, .flags, .process_word_first,
  .process_word_second, .reply_valid, .ref_word, .cmd);
`default_nettype wire

// *** test/serial_master_model.sv ***
// Serial bus master model: sends process blocks, asks for replies.
// Assumes tasks are called from the bench, one at a time.
`timescale 1ns/100ps
`default_nettype none
module serial_master_model (
  input wire logic clk,
  output logic [15:0] rx_word,
  output logic rx_word_valid,
  output logic reply_req
);
  initial begin
    rx_word = 16'h0000;
    rx_word_valid = 1'b0;
    reply_req = 1'b0;
  end
  // ==================================================================
  // Whole-number words, command first; line scrambled once released
  task automatic send(input logic [15:0] cw, input logic [15:0] rw);
    @(posedge clk);
    rx_word <= cw;
    rx_word_valid <= 1'b1;
    @(posedge clk);
    rx_word <= rw;
    @(posedge clk);
    rx_word_valid <= 1'b0;
    rx_word <= ~rw;
  endtask
  task automatic request_reply();
    @(posedge clk);
    reply_req <= 1'b1;
    @(posedge clk);
    reply_req <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** test/drive_cmd_logic_bench.sv ***
// Self-checking bench for the command and condition word logic.
// Assumes package, header, checker and master model compile first.
`timescale 1ns/100ps
`default_nettype none
module drive_cmd_logic_bench;
  logic clk, rst_n, clk_en, multi_setup_en, rx_word_valid, reply_req, reply_valid;
  logic [15:0] rx_word, out_freq, process_word_first, process_word_second, ref_word;
  drive_cmd_pkg::dig_in_t dig_in;
  drive_cmd_pkg::gate_cfg_t gate_cfg;
  drive_cmd_pkg::drive_flags_t flags;
  drive_cmd_pkg::drive_cmd_t cmd;
  int miscompares, tests_run, pulses;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Short watchdog keeps the relay drop-out wait brief
  drive_cmd_logic #(.TIMEOUT_CYCLES(50)) u_drive_cmd_logic (
    .clk, .rst_n, .clk_en, .rx_word, .rx_word_valid, .rx_frame_end(1'b0),
    .reply_req, .out_freq, .dig_in, .gate_cfg, .flags, .relay1_follows_bus(1'b1),
    .relay2_follows_bus(1'b0), .multi_setup_en, .process_word_first,
    .process_word_second, .reply_valid, .ref_word, .cmd);
  serial_master_model u_serial_master_model (.clk, .rx_word, .rx_word_valid, .reply_req);
  // ==================================================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Counts trip pulses, as a one-cycle pulse is easy to miss
  task automatic apply(input logic [15:0] cw, input logic [15:0] rw);
    pulses = 0;
    u_serial_master_model.send(cw, rw);
    repeat (5) begin
      @(negedge clk);
      pulses += int'(cmd.trip_reset === 1'b1);
    end
  endtask
  task automatic fetch(input logic [15:0] fl, input logic [15:0] fr);
    int n;
    @(posedge clk);
    flags <= drive_cmd_pkg::drive_flags_t'(fl[8:0]);
    out_freq <= fr;
    u_serial_master_model.request_reply();
    for (n = 0; n < 8; n++) begin
      @(negedge clk);
      if (reply_valid === 1'b1) break;
    end
    check(process_word_second, fr);
    if (n == 8) begin
      miscompares++;
      conclude();
    end
  endtask
  // ==================================================================
  // Scenarios
  task automatic scen_decode();
    logic [5:0] v;
    for (int p = 0; p < 4; p++) begin
      apply(16'h047c | 16'(p), 16'h2000);
      check(16'(cmd), {1'b0, 2'(p), 13'h0080});
    end
    apply(16'h8540, 16'h1111);
    v = {cmd.dc_brake, cmd.coast, cmd.quick_stop, cmd.freeze, cmd.jog, cmd.reverse};
    check(16'(v), 16'h003f);
    check(ref_word, 16'h1111);
  endtask
  task automatic scen_trip_valid();
    apply(16'h047f, 16'h2000);
    apply(16'h00ff, 16'h1234);
    check(16'(cmd), 16'h6080);
    check(ref_word, 16'h2000);
    check(16'(pulses), 16'h0000);
    apply(16'h04ff, 16'h2000);
    check(16'(pulses), 16'h0001);
    apply(16'h04ff, 16'h2000);
    check(16'(pulses), 16'h0000);
  endtask
  task automatic scen_freeze();
    apply(16'h045f, 16'h2000);
    check(16'({cmd.freeze, cmd.run}), 16'h0003);
    apply(16'h041f, 16'h2000);
    check(16'(cmd.run), 16'h0001);
    apply(16'h0417, 16'h2000);
    check(16'(cmd.run), 16'h0000);
  endtask
  task automatic scen_gating();
    @(posedge clk);
    gate_cfg.coast <= drive_cmd_pkg::gate_and;
    apply(16'h0477, 16'h2000);
    check(16'(cmd.coast), 16'h0000);
    @(posedge clk);
    dig_in.coast <= 1'b1;
    apply(16'h0477, 16'h2000);
    check(16'(cmd.coast), 16'h0001);
    @(posedge clk);
    gate_cfg.coast <= drive_cmd_pkg::gate_serial;
    dig_in.coast <= 1'b0;
  endtask
  // Frozen clock enable must swallow a whole telegram
  task automatic scen_enable();
    @(posedge clk);
    clk_en <= 1'b0;
    apply(16'h047f, 16'h3333);
    check(ref_word, 16'h2000);
    check(16'(cmd.coast), 16'h0001);
    @(posedge clk);
    clk_en <= 1'b1;
  endtask
  task automatic scen_relay();
    int n;
    apply(16'h5c7f, 16'h2000);
    check(16'(cmd), 16'h6094);
    for (n = 0; n < 80; n++) begin
      @(negedge clk);
      if (cmd.relay1 !== 1'b1) break;
    end
    check(16'(n > 40 && n < 60), 16'h0001);
    check(16'(cmd), 16'h6084);
    @(posedge clk);
    multi_setup_en <= 1'b0;
    repeat (2) @(negedge clk);
    check(16'(cmd.setup_sel), 16'h0000);
    if (n == 80) conclude();
  endtask
  task automatic scen_status();
    fetch(16'h01ff, 16'h2000);
    check(process_word_first, 16'hef88);
    fetch(16'h0000, 16'h1fff);
    check(process_word_first & 16'hfff9, 16'h0001);
    apply(16'h0477, 16'h2000);
    fetch(16'h0000, 16'h0400);
    check(process_word_first, 16'h0003);
  endtask
  initial begin
    miscompares = 0;
    tests_run = 0;
    rst_n = 1'b0;
    out_freq = 16'h0000;
    dig_in = '0;
    gate_cfg = {6{drive_cmd_pkg::gate_serial}};
    flags = '0;
    clk_en = 1'b1;
    multi_setup_en = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(16'(cmd), 16'h0000);
    scen_decode();
    scen_trip_valid();
    scen_freeze();
    scen_gating();
    scen_enable();
    scen_relay();
    scen_status();
    conclude();
  end
endmodule
`default_nettype wire
